// File: hw/cca_defines.svh
// Constants for the five-module counter array: register indices,
// mode and control bit positions, reset values.
// Assumes an APB slave where byte address = 4 * register index.
//
// What this block does
// - Either capture enable set puts the module into capture mode.
// - Capture mode watches the module input pin for enabled edges.
// - A valid edge copies both counter bytes into the compare bytes.
// - Module interrupt only when its event flag and flag enable are set.
// - Compare and match enables set: counter equal to compare raises match.
// - Writing the low compare byte clears compare enable.
// - Writing the high compare byte sets compare enable.
// - Compare enable stays readable and writable in the mode register.
// - Toggle, match and compare enables set, PWM clear: pin inverts on each match.
// - PWM: pin low while counter low byte below active byte, else high.
// - PWM active byte reloads from high compare byte on low-byte wrap.
// - PWM runs only with both the PWM bit and compare enable set.
// - Every module uses the one shared counter as time base.
// - Only module 4 can be a watchdog; otherwise it works normally.
// - Watchdog compares module 4 compare value to counter as in compare.
// - Watchdog match issues an internal reset, never the reset pin.
// - Clearing watchdog enable blocks the watchdog reset until set again.
// - Match enable set: a match sets the module event flag.
`ifndef CCA_DEFINES_SVH
`define CCA_DEFINES_SVH

`define CCA_IDX_CNT_LO 8'he9
`define CCA_IDX_CNT_HI 8'hf9
`define CCA_IDX_CMP_LO 8'hea
`define CCA_IDX_CMP_HI 8'hfa
`define CCA_IDX_MODE 8'hda
`define CCA_IDX_CTRL 8'hd8

`define CCA_MODE_COMPARE_ENABLE 6
`define CCA_MODE_RISE 5
`define CCA_MODE_FALL 4
`define CCA_MODE_MAT 3
`define CCA_MODE_TOG 2
`define CCA_MODE_PWM 1
`define CCA_MODE_IE 0
`define CCA_MODE_MASK 8'h7f

`define CCA_CTRL_RUN 6
`define CCA_CTRL_WATCHDOG_ENABLE 7

`define CCA_BYTE_RESET 8'h00
`define CCA_BYTE_MAX 8'hff
`define CCA_WDT_MODULE 4

`endif

// File: hw/cca_pkg.sv
// Types shared by the counter array design.
// Assumes cca_defines.svh supplies all numeric constants.
`default_nettype none
package cca_pkg;
  typedef enum logic [1:0] {
    PIN_IDLE = 2'b00,
    PIN_TOGGLE = 2'b01,
    PIN_PWM = 2'b10
  } pin_mode_t;
endpackage
`default_nettype wire

// File: hw/counter_array.sv
// Five-module capture/compare/PWM counter array with APB registers.
// Assumes synchronous pin inputs, one clock, zero-wait APB master.
//
// The APB register port was chosen for this implementation.
`include "cca_defines.svh"
`default_nettype none
module counter_array #(
  parameter int N_MOD = 5,
  parameter int AW = 10
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_tick,
  input wire logic [N_MOD-1:0] module_pin_in,
  output logic [N_MOD-1:0] module_pin_out,
  output logic [N_MOD-1:0] module_pin_oe,
  output logic [N_MOD-1:0] module_irq,
  output logic watchdog_reset
);

  function automatic logic hit(input logic [7:0] idx,
                               input logic [7:0] target);
    hit = (idx == target);
  endfunction

  logic [15:0] cnt_reg;
  logic adv_reg;
  logic [7:0] ctrl_reg;
  logic [N_MOD-1:0] flag_reg;
  logic [7:0] mode_reg [N_MOD];
  logic [7:0] cmp_lo_reg [N_MOD];
  logic [7:0] cmp_hi_reg [N_MOD];
  logic [7:0] pwm_lo_reg [N_MOD];
  logic [N_MOD-1:0] pin_prev_reg;
  logic [N_MOD-1:0] cap_ev;
  logic [N_MOD-1:0] match;
  logic [N_MOD-1:0] pwm_act;
  logic [7:0] idx;
  logic wr_en;
  logic setup;
  logic tick;
  logic wrap;
  logic cnt_wr;
  logic [7:0] rd_data;
  logic rd_ok;

  assign idx = paddr[AW-1:2];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;
  assign tick = count_tick && ctrl_reg[`CCA_CTRL_RUN];
  assign wrap = tick && (cnt_reg[7:0] == `CCA_BYTE_MAX);
  assign cnt_wr = wr_en && (hit(idx, `CCA_IDX_CNT_LO) ||
                            hit(idx, `CCA_IDX_CNT_HI));

  // Per-module event decode
  always_comb begin
    for (int i = 0; i < N_MOD; i++) begin
      cap_ev[i] = (mode_reg[i][`CCA_MODE_RISE] &&
                   module_pin_in[i] && !pin_prev_reg[i]) ||
                  (mode_reg[i][`CCA_MODE_FALL] &&
                   !module_pin_in[i] && pin_prev_reg[i]);
      match[i] = adv_reg && mode_reg[i][`CCA_MODE_COMPARE_ENABLE] &&
                 mode_reg[i][`CCA_MODE_MAT] &&
                 ({cmp_hi_reg[i], cmp_lo_reg[i]} == cnt_reg);
      pwm_act[i] = mode_reg[i][`CCA_MODE_PWM] &&
                   mode_reg[i][`CCA_MODE_COMPARE_ENABLE];
    end
  end

  // Read mux
  always_comb begin
    rd_data = `CCA_BYTE_RESET;
    rd_ok = 1'b1;
    if (hit(idx, `CCA_IDX_CNT_LO)) begin
      rd_data = cnt_reg[7:0];
    end else if (hit(idx, `CCA_IDX_CNT_HI)) begin
      rd_data = cnt_reg[15:8];
    end else if (hit(idx, `CCA_IDX_CTRL)) begin
      rd_data = ctrl_reg | 8'(flag_reg);
    end else begin
      rd_ok = 1'b0;
      for (int i = 0; i < N_MOD; i++) begin
        if (hit(idx, 8'(`CCA_IDX_MODE + i))) begin
          rd_data = mode_reg[i];
          rd_ok = 1'b1;
        end
        if (hit(idx, 8'(`CCA_IDX_CMP_LO + i))) begin
          rd_data = cmp_lo_reg[i];
          rd_ok = 1'b1;
        end
        if (hit(idx, 8'(`CCA_IDX_CMP_HI + i))) begin
          rd_data = cmp_hi_reg[i];
          rd_ok = 1'b1;
        end
      end
    end
  end

  // APB answer: ready in the first access cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !rd_ok;
      if (setup && !pwrite) begin
        prdata <= {24'h00_0000, rd_data};
      end
    end
  end

  // Shared counter
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 16'h0000;
      adv_reg <= 1'b0;
    end else begin
      adv_reg <= tick || cnt_wr;
      if (wr_en && hit(idx, `CCA_IDX_CNT_LO)) begin
        cnt_reg[7:0] <= pwdata[7:0];
      end else if (wr_en && hit(idx, `CCA_IDX_CNT_HI)) begin
        cnt_reg[15:8] <= pwdata[7:0];
      end else if (tick) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  // Control register: run, watchdog enable
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `CCA_BYTE_RESET;
    end else if (wr_en && hit(idx, `CCA_IDX_CTRL)) begin
      ctrl_reg <= {pwdata[`CCA_CTRL_WATCHDOG_ENABLE], pwdata[`CCA_CTRL_RUN], 6'h00};
    end
  end

  // Event flags: write zero clears, hardware set wins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= '0;
    end else begin
      for (int i = 0; i < N_MOD; i++) begin
        if (match[i] || cap_ev[i]) begin
          flag_reg[i] <= 1'b1;
        end else if (wr_en && hit(idx, `CCA_IDX_CTRL) && !pwdata[i]) begin
          flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Mode registers and compare enable side effects
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N_MOD; i++) begin
        mode_reg[i] <= `CCA_BYTE_RESET;
      end
    end else begin
      for (int i = 0; i < N_MOD; i++) begin
        if (wr_en && hit(idx, 8'(`CCA_IDX_MODE + i))) begin
          mode_reg[i] <= pwdata[7:0] & `CCA_MODE_MASK;
        end else if (wr_en && hit(idx, 8'(`CCA_IDX_CMP_LO + i))) begin
          mode_reg[i][`CCA_MODE_COMPARE_ENABLE] <= 1'b0;
        end else if (wr_en && hit(idx, 8'(`CCA_IDX_CMP_HI + i))) begin
          mode_reg[i][`CCA_MODE_COMPARE_ENABLE] <= 1'b1;
        end
      end
    end
  end

  // Compare bytes: capture load beats software write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N_MOD; i++) begin
        cmp_lo_reg[i] <= `CCA_BYTE_RESET;
        cmp_hi_reg[i] <= `CCA_BYTE_RESET;
      end
    end else begin
      for (int i = 0; i < N_MOD; i++) begin
        if (cap_ev[i]) begin
          cmp_lo_reg[i] <= cnt_reg[7:0];
          cmp_hi_reg[i] <= cnt_reg[15:8];
        end else begin
          if (wr_en && hit(idx, 8'(`CCA_IDX_CMP_LO + i))) begin
            cmp_lo_reg[i] <= pwdata[7:0];
          end
          if (wr_en && hit(idx, 8'(`CCA_IDX_CMP_HI + i))) begin
            cmp_hi_reg[i] <= pwdata[7:0];
          end
        end
      end
    end
  end

  // PWM active low byte
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N_MOD; i++) begin
        pwm_lo_reg[i] <= `CCA_BYTE_RESET;
      end
    end else begin
      for (int i = 0; i < N_MOD; i++) begin
        if (wrap) begin
          pwm_lo_reg[i] <= cmp_hi_reg[i];
        end
      end
    end
  end

  // Pin sampling for edge detection
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_prev_reg <= '0;
    end else begin
      pin_prev_reg <= module_pin_in;
    end
  end

  // Module pin drive
  always_ff @(posedge clk_sys or negedge reset_n) begin
    cca_pkg::pin_mode_t pm;
    if (!reset_n) begin
      module_pin_out <= '0;
      module_pin_oe <= '0;
    end else begin
      for (int i = 0; i < N_MOD; i++) begin
        pm = pwm_act[i] ? cca_pkg::PIN_PWM :
             (mode_reg[i][`CCA_MODE_TOG] && mode_reg[i][`CCA_MODE_COMPARE_ENABLE])
             ? cca_pkg::PIN_TOGGLE : cca_pkg::PIN_IDLE;
        case (pm)
          cca_pkg::PIN_PWM: begin
            module_pin_out[i] <= (cnt_reg[7:0] >= pwm_lo_reg[i]);
            module_pin_oe[i] <= 1'b1;
          end
          cca_pkg::PIN_TOGGLE: begin
            if (match[i]) begin
              module_pin_out[i] <= !module_pin_out[i];
            end
            module_pin_oe[i] <= 1'b1;
          end
          default: begin
            module_pin_oe[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // Interrupt requests and watchdog
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      module_irq <= '0;
      watchdog_reset <= 1'b0;
    end else begin
      for (int i = 0; i < N_MOD; i++) begin
        module_irq[i] <= flag_reg[i] && mode_reg[i][`CCA_MODE_IE];
      end
      watchdog_reset <= match[`CCA_WDT_MODULE] &&
                        ctrl_reg[`CCA_CTRL_WATCHDOG_ENABLE];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_CAPTURE_LOAD: assert property (
    cap_ev[0] |=> {cmp_hi_reg[0], cmp_lo_reg[0]} == $past(cnt_reg))
    else $error("capture did not load counter");
  AST_IRQ_GATED: assert property (
    module_irq[1] |-> $past(flag_reg[1]) && $past(mode_reg[1][0]))
    else $error("interrupt without flag and enable");
  AST_MATCH_FLAG: assert property (
    match[2] |=> flag_reg[2])
    else $error("match did not set flag");
  AST_LOW_CLEARS: assert property (
    wr_en && hit(idx, 8'hea) |=> !mode_reg[0][6])
    else $error("low compare write left compare enabled");
  AST_HIGH_SETS: assert property (
    wr_en && hit(idx, 8'hfa) |=> mode_reg[0][6])
    else $error("high compare write did not enable compare");
  AST_TOGGLE: assert property (
    match[3] && mode_reg[3][2] && !mode_reg[3][1]
    |=> module_pin_out[3] != $past(module_pin_out[3]))
    else $error("pin did not toggle on match");
  AST_PWM_LEVEL: assert property (
    pwm_act[0] |=> module_pin_out[0] ==
      ($past(cnt_reg[7:0]) >= $past(pwm_lo_reg[0])))
    else $error("pwm level wrong");
  AST_PWM_RELOAD: assert property (
    wrap |=> pwm_lo_reg[1] == $past(cmp_hi_reg[1]))
    else $error("pwm byte not reloaded on wrap");
  AST_WDT_FIRE: assert property (
    match[4] && ctrl_reg[7] |=> watchdog_reset)
    else $error("watchdog match gave no reset");
  AST_WDT_OFF: assert property (
    !ctrl_reg[7] |=> !watchdog_reset)
    else $error("watchdog reset while disabled");
  AST_COUNT: assert property (
    tick && !cnt_wr |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("counter did not step");

  COV_CAPTURE: cover property (cap_ev[0] ##1 flag_reg[0]);
  COV_WDT: cover property (watchdog_reset);
  COV_PWM_WRAP: cover property (pwm_act[0] && wrap);

endmodule
`default_nettype wire

// File: tb/pin_partner.sv
// External lines on the five module pins.
// Assumes the bench sets the level driven onto pins the design leaves free.
`default_nettype none
module pin_partner (
  input wire logic [4:0] drive,
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe,
  output logic [4:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Design wins where it drives, else the outside source
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule
`default_nettype wire

// File: tb/tb.sv
// Bench for the counter array: APB master, tick source, pin partner.
// Assumes a zero-wait APB slave and pins looped through pin_partner.
`include "cca_defines.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
  logic count_tick, watchdog_reset, last_err;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] drive, pin_in, pin_out, pin_oe, irq;
  int err_total, num_checks, wd_cnt;
  counter_array i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_tick(count_tick), .module_pin_in(pin_in),
    .module_pin_out(pin_out), .module_pin_oe(pin_oe), .module_irq(irq),
    .watchdog_reset(watchdog_reset));
  pin_partner i_pins (.drive(drive), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      $display("[ERR] apb_ready expected 1 seen %b", pready);
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx, exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, rd, {24'h000000, exp});
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      count_tick <= 1'b1;
    end
    @(posedge clk_sys);
    count_tick <= 1'b0;
  endtask
  task automatic setcnt(input logic [7:0] hi, lo);
    wr(`CCA_IDX_CNT_LO, lo);
    wr(`CCA_IDX_CNT_HI, hi);
  endtask
  task automatic t_reset;
    rdc("cnt_lo", `CCA_IDX_CNT_LO, 8'h00);
    rdc("cnt_hi", `CCA_IDX_CNT_HI, 8'h00);
    rdc("ctrl", `CCA_IDX_CTRL, 8'h00);
    rdc("unmapped", 8'h00, 8'h00);
    chk("pslverr", {31'h0, last_err}, 32'h1);
    wr(`CCA_IDX_CTRL, 8'h40);
    setcnt(8'hff, 8'hfe);
    tick(3);
    rdc("wrap_lo", `CCA_IDX_CNT_LO, 8'h01);
    rdc("wrap_hi", `CCA_IDX_CNT_HI, 8'h00);
  endtask
  task automatic t_capture;
    wr(`CCA_IDX_MODE + 8'd1, 8'h21);
    wr(`CCA_IDX_MODE + 8'd2, 8'h10);
    setcnt(8'h12, 8'h34);
    @(posedge clk_sys);
    drive <= 5'b00010;
    settle;
    rdc("cap1_lo", `CCA_IDX_CMP_LO + 8'd1, 8'h34);
    rdc("cap1_hi", `CCA_IDX_CMP_HI + 8'd1, 8'h12);
    rdc("cap2_hi", `CCA_IDX_CMP_HI + 8'd2, 8'h12);
    rdc("cap_flags", `CCA_IDX_CTRL, 8'h46);
    chk("irq", {27'h0, irq}, 32'h2);
    setcnt(8'h55, 8'h66);
    @(posedge clk_sys);
    drive <= 5'b00100;
    settle;
    rdc("keep1", `CCA_IDX_CMP_LO + 8'd1, 8'h34);
    rdc("keep2", `CCA_IDX_CMP_LO + 8'd2, 8'h34);
    wr(`CCA_IDX_CTRL, 8'h40);
    settle;
    chk("irq_clr", {27'h0, irq}, 32'h0);
  endtask
  task automatic t_compare;
    wr(`CCA_IDX_MODE, 8'h48);
    wr(`CCA_IDX_CMP_LO, 8'h05);
    rdc("compare_enable_clr", `CCA_IDX_MODE, 8'h08);
    wr(`CCA_IDX_CMP_HI, 8'h00);
    rdc("compare_enable_set", `CCA_IDX_MODE, 8'h48);
    setcnt(8'h00, 8'h03);
    tick(2);
    settle;
    rdc("match", `CCA_IDX_CTRL, 8'h41);
    wr(`CCA_IDX_CTRL, 8'h40);
    wr(`CCA_IDX_MODE, 8'h08);
    rdc("compare_enable_rw", `CCA_IDX_MODE, 8'h08);
    setcnt(8'h00, 8'h04);
    tick(1);
    settle;
    rdc("no_match", `CCA_IDX_CTRL, 8'h40);
  endtask
  task automatic t_toggle;
    logic p;
    wr(`CCA_IDX_CMP_LO + 8'd3, 8'h10);
    wr(`CCA_IDX_CMP_HI + 8'd3, 8'h00);
    wr(`CCA_IDX_MODE + 8'd3, 8'h4c);
    setcnt(8'h00, 8'h0e);
    settle;
    p = pin_out[3];
    chk("tog_oe", {31'h0, pin_oe[3]}, 32'h1);
    tick(2);
    settle;
    chk("tog1", {31'h0, pin_out[3]}, {31'h0, ~p});
    setcnt(8'h00, 8'h0f);
    tick(1);
    settle;
    chk("tog2", {31'h0, pin_out[3]}, {31'h0, p});
  endtask
  task automatic t_pwm;
    wr(`CCA_IDX_CMP_LO + 8'd2, 8'h80);
    wr(`CCA_IDX_CMP_HI + 8'd2, 8'h80);
    wr(`CCA_IDX_MODE + 8'd2, 8'h42);
    setcnt(8'h00, 8'hff);
    tick(1);
    setcnt(8'h00, 8'h10);
    settle;
    chk("pwm_lo", {31'h0, pin_out[2]}, 32'h0);
    chk("pwm_oe", {31'h0, pin_oe[2]}, 32'h1);
    setcnt(8'h00, 8'h80);
    settle;
    chk("pwm_eq", {31'h0, pin_out[2]}, 32'h1);
    wr(`CCA_IDX_CMP_HI + 8'd2, 8'h20);
    setcnt(8'h00, 8'h40);
    settle;
    chk("pwm_hold", {31'h0, pin_out[2]}, 32'h0);
    setcnt(8'h00, 8'hff);
    tick(1);
    setcnt(8'h00, 8'h30);
    settle;
    chk("pwm_reload", {31'h0, pin_out[2]}, 32'h1);
    wr(`CCA_IDX_MODE + 8'd2, 8'h02);
    settle;
    chk("pwm_off", {31'h0, pin_oe[2]}, 32'h0);
  endtask
  task automatic t_wdog;
    wr(`CCA_IDX_CMP_LO + 8'd4, 8'h00);
    wr(`CCA_IDX_CMP_HI + 8'd4, 8'h01);
    wr(`CCA_IDX_MODE + 8'd4, 8'h48);
    wr(`CCA_IDX_CTRL, 8'hc0);
    setcnt(8'h00, 8'hff);
    wd_cnt = 0;
    tick(1);
    settle;
    chk("wd_pulse", wd_cnt, 32'h1);
    rdc("wd_keep", `CCA_IDX_MODE + 8'd4, 8'h48);
    wr(`CCA_IDX_CTRL, 8'h40);
    setcnt(8'h00, 8'hff);
    wd_cnt = 0;
    tick(1);
    settle;
    chk("wd_off", wd_cnt, 32'h0);
    rdc("wd_flag", `CCA_IDX_CTRL, 8'h50);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (watchdog_reset === 1'b1) begin
      wd_cnt <= wd_cnt + 1;
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    err_total++;
    give_verdict;
  end
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h00000000;
    count_tick = 1'b0;
    drive = 5'b00100;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset;
    t_capture;
    t_compare;
    t_toggle;
    t_pwm;
    t_wdog;
    give_verdict;
  end
endmodule
`default_nettype wire
